// [rtl/pid_accel_pkg.sv]
package pid_accel_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int OPERAND_W = 16;
  localparam int ERR_W = 17;
  localparam int ACC_W = 35;
  localparam int MODE_W = 3;

  // Register byte addresses, one aligned word each
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_INPUT_HIGH = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_INPUT_LOW = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_SET_POINT = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_COEFF_CURRENT = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_COEFF_PRIOR = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_COEFF_SECOND = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_RESULT_LOW = 8'h1c;
  localparam logic [ADDR_W-1:0] ADDR_RESULT_HIGH = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_HISTORY_ONE = 8'h24;
  localparam logic [ADDR_W-1:0] ADDR_HISTORY_TWO = 8'h28;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_FLAGS = 8'h2c;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = 8'h30;

  // Control and interrupt register bit layout
  localparam int CTRL_ENABLE_BIT = 7;
  localparam int CTRL_BUSY_BIT = 6;
  localparam int CTRL_MODE_LSB = 0;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_OVERFLOW_BIT = 1;

  localparam logic [MODE_W-1:0] MODE_UNSIGNED_PLAIN = 3'h0;
  localparam logic [MODE_W-1:0] MODE_UNSIGNED_ACCUM = 3'h1;
  localparam logic [MODE_W-1:0] MODE_SIGNED_PLAIN = 3'h2;
  localparam logic [MODE_W-1:0] MODE_SIGNED_ACCUM = 3'h3;
  localparam logic [MODE_W-1:0] MODE_PID = 3'h5;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    CALC_IDLE,
    CALC_TERM_CURRENT,
    CALC_TERM_PRIOR,
    CALC_TERM_SECOND,
    CALC_FINISH
  } calc_state_e;

  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_full;
    logic w_full;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic [3:0] wr_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [DATA_W-1:0] rdata;
    logic enable;
    logic busy;
    logic [MODE_W-1:0] mode;
    logic [7:0] input_operand_high;
    logic [7:0] input_operand_low;
    logic [OPERAND_W-1:0] set_point_operand;
    logic [OPERAND_W-1:0] coeff_current_error;
    logic [OPERAND_W-1:0] coeff_prior_error;
    logic [OPERAND_W-1:0] coeff_second_prior_error;
    logic [ACC_W-1:0] result_output;
    logic [ERR_W-1:0] error_history_one;
    logic [ERR_W-1:0] error_history_two;
    logic [ERR_W-1:0] error_now;
    logic [ACC_W-1:0] acc_work;
    logic overflow_seen;
    logic done_irq_flag;
    logic overflow_irq_flag;
    logic done_irq_enable;
    logic overflow_irq_enable;
    logic done_irq;
    logic overflow_irq;
    calc_state_e state;
  } accel_regs_s;

endpackage

// [rtl/pid_math_accelerator.sv]
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module pid_math_accelerator (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [pid_accel_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [pid_accel_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [pid_accel_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [pid_accel_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic done_irq_request,
  output logic overflow_irq_request
);
  import pid_accel_pkg::*;

  localparam accel_regs_s REGS_RESET = '{
    awready: 1'b1,
    wready: 1'b1,
    arready: 1'b1,
    state: CALC_IDLE,
    default: '0
  };

  accel_regs_s r;
  accel_regs_s next_r;

  function automatic logic [DATA_W-1:0] merge_bytes(
    input logic [DATA_W-1:0] old_value,
    input logic [DATA_W-1:0] new_value,
    input logic [3:0] strb
  );
    logic [DATA_W-1:0] mask;
    for (int i = 0; i < 4; i++) begin
      mask[i*8 +: 8] = {8{strb[i]}};
    end
    return (old_value & ~mask) | (new_value & mask);
  endfunction

  function automatic logic [17:0] extend_operand(
    input logic [OPERAND_W-1:0] value,
    input logic signed_mode
  );
    return signed_mode ? {{2{value[OPERAND_W-1]}}, value} : {2'h0, value};
  endfunction

  function automatic logic is_pid(input logic [MODE_W-1:0] mode);
    return mode == MODE_PID;
  endfunction

  // Signed modes and PID sign-extend, reserved codes fall to the add-multiply path
  function automatic logic is_signed(input logic [MODE_W-1:0] mode);
    return is_pid(mode) || mode == MODE_SIGNED_PLAIN || mode == MODE_SIGNED_ACCUM;
  endfunction

  function automatic logic accumulates(input logic [MODE_W-1:0] mode);
    return is_pid(mode) || mode == MODE_UNSIGNED_ACCUM || mode == MODE_SIGNED_ACCUM;
  endfunction

  // One extra bit catches the carry; the kept sum simply wraps
  function automatic logic [ACC_W:0] add_with_overflow(
    input logic [ACC_W-1:0] acc,
    input logic [ACC_W-1:0] term,
    input logic signed_mode
  );
    logic [ACC_W:0] sum;
    logic overflow;
    if (signed_mode) begin
      sum = {acc[ACC_W-1], acc} + {term[ACC_W-1], term};
      overflow = sum[ACC_W] ^ sum[ACC_W-1];
    end else begin
      sum = {1'b0, acc} + {1'b0, term};
      overflow = sum[ACC_W];
    end
    return {overflow, sum[ACC_W-1:0]};
  endfunction

  logic do_write;
  logic start_calc;
  logic [DATA_W-1:0] merged;
  logic [OPERAND_W-1:0] input_word;
  logic [17:0] mult_a;
  logic [16:0] mult_b;
  logic signed [ACC_W-1:0] product;
  logic [ACC_W:0] acc_sum;

  always_comb begin
    next_r = r;
    do_write = 1'b0;
    start_calc = 1'b0;
    merged = '0;
    input_word = '0;
    mult_a = '0;
    mult_b = '0;
    product = '0;
    acc_sum = '0;

    // Address and data are held separately so either may arrive first
    if (awvalid && r.awready) begin
      next_r.aw_full = 1'b1;
      next_r.awready = 1'b0;
      next_r.wr_addr = awaddr;
    end
    if (wvalid && r.wready) begin
      next_r.w_full = 1'b1;
      next_r.wready = 1'b0;
      next_r.wr_data = wdata;
      next_r.wr_strb = wstrb;
    end
    if (r.bvalid && bready) begin
      next_r.bvalid = 1'b0;
      next_r.awready = 1'b1;
      next_r.wready = 1'b1;
    end

    do_write = r.aw_full && r.w_full && !r.bvalid;
    if (do_write) begin
      next_r.aw_full = 1'b0;
      next_r.w_full = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = RESP_OKAY;
      case (r.wr_addr)
        ADDR_CONTROL: begin
          merged = merge_bytes({24'h0, r.enable, 4'h0, r.mode}, r.wr_data, r.wr_strb);
          next_r.enable = merged[CTRL_ENABLE_BIT];
          next_r.mode = merged[CTRL_MODE_LSB +: MODE_W];
        end
        ADDR_INPUT_HIGH: begin
          merged = merge_bytes({24'h0, r.input_operand_high}, r.wr_data, r.wr_strb);
          next_r.input_operand_high = merged[7:0];
        end
        ADDR_INPUT_LOW: begin
          merged = merge_bytes({24'h0, r.input_operand_low}, r.wr_data, r.wr_strb);
          next_r.input_operand_low = merged[7:0];
          if (r.wr_strb[0] && r.enable && !r.busy) begin
            start_calc = 1'b1;
          end
        end
        ADDR_SET_POINT: begin
          merged = merge_bytes({16'h0, r.set_point_operand}, r.wr_data, r.wr_strb);
          next_r.set_point_operand = merged[OPERAND_W-1:0];
        end
        ADDR_COEFF_CURRENT: begin
          merged = merge_bytes({16'h0, r.coeff_current_error}, r.wr_data, r.wr_strb);
          next_r.coeff_current_error = merged[OPERAND_W-1:0];
        end
        ADDR_COEFF_PRIOR: begin
          merged = merge_bytes({16'h0, r.coeff_prior_error}, r.wr_data, r.wr_strb);
          next_r.coeff_prior_error = merged[OPERAND_W-1:0];
        end
        ADDR_COEFF_SECOND: begin
          merged = merge_bytes({16'h0, r.coeff_second_prior_error}, r.wr_data, r.wr_strb);
          next_r.coeff_second_prior_error = merged[OPERAND_W-1:0];
        end
        ADDR_RESULT_LOW: begin
          merged = merge_bytes(r.result_output[31:0], r.wr_data, r.wr_strb);
          next_r.result_output[31:0] = merged;
        end
        ADDR_RESULT_HIGH: begin
          merged = merge_bytes({29'h0, r.result_output[ACC_W-1:32]}, r.wr_data, r.wr_strb);
          next_r.result_output[ACC_W-1:32] = merged[2:0];
        end
        ADDR_HISTORY_ONE: begin
          merged = merge_bytes({15'h0, r.error_history_one}, r.wr_data, r.wr_strb);
          next_r.error_history_one = merged[ERR_W-1:0];
        end
        ADDR_HISTORY_TWO: begin
          merged = merge_bytes({15'h0, r.error_history_two}, r.wr_data, r.wr_strb);
          next_r.error_history_two = merged[ERR_W-1:0];
        end
        ADDR_IRQ_FLAGS: begin
          // Write one to clear; a completion in the same cycle sets it again below
          if (r.wr_strb[0] && r.wr_data[IRQ_DONE_BIT]) begin
            next_r.done_irq_flag = 1'b0;
          end
          if (r.wr_strb[0] && r.wr_data[IRQ_OVERFLOW_BIT]) begin
            next_r.overflow_irq_flag = 1'b0;
          end
        end
        ADDR_IRQ_ENABLE: begin
          if (r.wr_strb[0]) begin
            next_r.done_irq_enable = r.wr_data[IRQ_DONE_BIT];
            next_r.overflow_irq_enable = r.wr_data[IRQ_OVERFLOW_BIT];
          end
        end
        default: begin
          next_r.bresp = RESP_SLVERR;
        end
      endcase
    end

    if (r.rvalid && rready) begin
      next_r.rvalid = 1'b0;
      next_r.arready = 1'b1;
    end
    if (arvalid && r.arready) begin
      next_r.arready = 1'b0;
      next_r.rvalid = 1'b1;
      next_r.rresp = RESP_OKAY;
      case (araddr)
        ADDR_CONTROL: next_r.rdata = {24'h0, r.enable, r.busy, 3'h0, r.mode};
        ADDR_INPUT_HIGH: next_r.rdata = {24'h0, r.input_operand_high};
        ADDR_INPUT_LOW: next_r.rdata = {24'h0, r.input_operand_low};
        ADDR_SET_POINT: next_r.rdata = {16'h0, r.set_point_operand};
        ADDR_COEFF_CURRENT: next_r.rdata = {16'h0, r.coeff_current_error};
        ADDR_COEFF_PRIOR: next_r.rdata = {16'h0, r.coeff_prior_error};
        ADDR_COEFF_SECOND: next_r.rdata = {16'h0, r.coeff_second_prior_error};
        ADDR_RESULT_LOW: next_r.rdata = r.result_output[31:0];
        ADDR_RESULT_HIGH: next_r.rdata = {29'h0, r.result_output[ACC_W-1:32]};
        ADDR_HISTORY_ONE: next_r.rdata = {15'h0, r.error_history_one};
        ADDR_HISTORY_TWO: next_r.rdata = {15'h0, r.error_history_two};
        ADDR_IRQ_FLAGS: next_r.rdata = {30'h0, r.overflow_irq_flag, r.done_irq_flag};
        ADDR_IRQ_ENABLE: next_r.rdata = {30'h0, r.overflow_irq_enable, r.done_irq_enable};
        default: begin
          next_r.rdata = '0;
          next_r.rresp = RESP_SLVERR;
        end
      endcase
    end

    // One shared multiplier, one product per cycle
    input_word = {r.input_operand_high, r.input_operand_low};
    case (r.state)
      CALC_TERM_CURRENT: begin
        if (is_pid(r.mode)) begin
          mult_a = {r.error_now[ERR_W-1], r.error_now};
        end else begin
          mult_a = extend_operand(input_word, is_signed(r.mode))
            + extend_operand(r.set_point_operand, is_signed(r.mode));
        end
        mult_b = {is_signed(r.mode) & r.coeff_current_error[OPERAND_W-1],
          r.coeff_current_error};
      end
      CALC_TERM_PRIOR: begin
        mult_a = {r.error_history_one[ERR_W-1], r.error_history_one};
        mult_b = {r.coeff_prior_error[OPERAND_W-1], r.coeff_prior_error};
      end
      CALC_TERM_SECOND: begin
        mult_a = {r.error_history_two[ERR_W-1], r.error_history_two};
        mult_b = {r.coeff_second_prior_error[OPERAND_W-1], r.coeff_second_prior_error};
      end
      default: begin
        mult_a = '0;
        mult_b = '0;
      end
    endcase
    product = ACC_W'($signed(mult_a)) * ACC_W'($signed(mult_b));
    acc_sum = add_with_overflow(r.acc_work, product, is_signed(r.mode));

    case (r.state)
      CALC_IDLE: begin
        if (start_calc) begin
          next_r.busy = 1'b1;
          next_r.overflow_seen = 1'b0;
          next_r.acc_work = accumulates(r.mode) ? r.result_output : '0;
          next_r.error_now = {r.set_point_operand[OPERAND_W-1], r.set_point_operand}
            - {r.input_operand_high[7], r.input_operand_high, next_r.input_operand_low};
          next_r.state = CALC_TERM_CURRENT;
        end
      end
      CALC_TERM_CURRENT: begin
        next_r.acc_work = acc_sum[ACC_W-1:0];
        next_r.overflow_seen = acc_sum[ACC_W];
        next_r.state = is_pid(r.mode) ? CALC_TERM_PRIOR : CALC_FINISH;
      end
      CALC_TERM_PRIOR: begin
        next_r.acc_work = acc_sum[ACC_W-1:0];
        next_r.overflow_seen = r.overflow_seen | acc_sum[ACC_W];
        next_r.state = CALC_TERM_SECOND;
      end
      CALC_TERM_SECOND: begin
        next_r.acc_work = acc_sum[ACC_W-1:0];
        next_r.overflow_seen = r.overflow_seen | acc_sum[ACC_W];
        next_r.state = CALC_FINISH;
      end
      CALC_FINISH: begin
        next_r.result_output = r.acc_work;
        next_r.busy = 1'b0;
        next_r.done_irq_flag = 1'b1;
        if (r.overflow_seen) begin
          next_r.overflow_irq_flag = 1'b1;
        end
        if (is_pid(r.mode)) begin
          next_r.error_history_two = r.error_history_one;
          next_r.error_history_one = r.error_now;
        end
        next_r.state = CALC_IDLE;
      end
      default: begin
        next_r.state = CALC_IDLE;
      end
    endcase

    next_r.done_irq = next_r.done_irq_flag & next_r.done_irq_enable;
    next_r.overflow_irq = next_r.overflow_irq_flag & next_r.overflow_irq_enable;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= REGS_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign awready = r.awready;
  assign wready = r.wready;
  assign bvalid = r.bvalid;
  assign bresp = r.bresp;
  assign arready = r.arready;
  assign rvalid = r.rvalid;
  assign rresp = r.rresp;
  assign rdata = r.rdata;
  assign done_irq_request = r.done_irq;
  assign overflow_irq_request = r.overflow_irq;

endmodule // pid_math_accelerator

`default_nettype wire

// [test/pid_math_accelerator_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
module pid_accel_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [pid_accel_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [pid_accel_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [pid_accel_pkg::DATA_W-1:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic done_irq_request,
  input wire logic overflow_irq_request
);
  import pid_accel_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic bad_aw;
  wire aw_go = awvalid && awready;
  wire ar_go = arvalid && arready;
  function automatic logic bad(logic [ADDR_W-1:0] a);
    return a > ADDR_IRQ_ENABLE || a[1:0] != 2'h0;
  endfunction
  // Kept from the AW handshake, since the response is judged cycles later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bad_aw <= 1'h0;
    end else if (aw_go) begin
      bad_aw <= bad(awaddr);
    end
  end
  a_b_stand: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_r_stand: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read response dropped early");
  a_b_timing: assert property (aw_go && wvalid && wready |-> ##2 bvalid)
    else $error("write response late");
  a_r_timing: assert property (ar_go |=> rvalid)
    else $error("read response late");
  a_aw_blocked: assert property (bvalid |-> !awready && !wready)
    else $error("write taken during response");
  a_ar_blocked: assert property (rvalid |-> !arready)
    else $error("read taken during response");
  a_write_resp: assert property ($rose(bvalid) |-> bresp == (bad_aw ? RESP_SLVERR : RESP_OKAY))
    else $error("wrong write response code");
  a_read_bad: assert property (ar_go && bad(araddr) |=> rresp == RESP_SLVERR && rdata == 32'h0)
    else $error("unmapped read not refused");
  a_done_fall: assert property ($fell(done_irq_request) |-> !awready || !$past(awready))
    else $error("done request dropped without a write");
  a_ovf_fall: assert property ($fell(overflow_irq_request) |-> !awready || !$past(awready))
    else $error("overflow request dropped without a write");
  c_start: cover property (aw_go && awaddr == ADDR_INPUT_LOW);
  c_done: cover property ($rose(done_irq_request));
  c_ovf: cover property ($rose(overflow_irq_request));
  c_bad: cover property (ar_go && bad(araddr));
endmodule // pid_accel_checker

bind pid_math_accelerator pid_accel_checker pid_accel_checker_i (
  .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
  .rvalid(rvalid), .rready(rready), .done_irq_request(done_irq_request),
  .overflow_irq_request(overflow_irq_request)
);
`default_nettype wire

// [test/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import pid_accel_pkg::*;
  // Half of the 35-bit accumulator span
  localparam longint LIM = 64'sh400000000;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [ADDR_W-1:0] awaddr = 8'h0, araddr = 8'h0;
  logic [DATA_W-1:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  wire logic awready, wready, bvalid, arready, rvalid, dirq, oirq;
  wire logic [1:0] bresp, rresp;
  wire logic [DATA_W-1:0] rdata;
  int err_total = 0;
  int comparisons = 0;
  logic [34:0] out_m = 35'h0;
  longint z1_m = 0, z2_m = 0;
  logic ov_m;
  logic [1:0] ien;
  logic [2:0] mode_c;
  logic [15:0] set_c, k1_c, k2_c, k3_c;
  logic [31:0] d;
  logic [1:0] r;
  logic [7:0] bad_addr [3] = '{8'h34, 8'h06, 8'hfc};

  pid_math_accelerator pid_math_accelerator_i (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .done_irq_request(dirq), .overflow_irq_request(oirq)
  );

  task automatic chk(string n, logic [34:0] e, logic [34:0] s);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  // A late bready now and then makes the response wait and hold
  task automatic wr(logic [7:0] a, logic [31:0] v, output logic [1:0] q);
    bit slow;
    slow = 1'($urandom);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hf;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= !slow;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid && !bready) bready <= 1'h1;
    end while (!(bvalid && bready));
    q = bresp;
    bready <= 1'h0;
  endtask

  task automatic rd(logic [7:0] a, output logic [31:0] v, output logic [1:0] q);
    bit slow;
    slow = 1'($urandom);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= !slow;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid && !rready) rready <= 1'h1;
    end while (!(rvalid && rready));
    v = rdata;
    q = rresp;
    rready <= 1'h0;
  endtask

  function automatic longint sx(logic [16:0] x);
    return longint'($signed(x));
  endfunction

  // Wraps after every partial sum, flagging overflow as it goes
  function automatic longint acc(longint a, longint t, bit sg);
    longint s;
    s = a + t;
    if (sg ? (s >= LIM || s < -LIM) : s >= 2 * LIM) ov_m = 1'h1;
    s = s & (2 * LIM - 1);
    if (sg && s >= LIM) s -= 2 * LIM;
    return s;
  endfunction

  function automatic void model(logic [15:0] i);
    longint a, e;
    bit sg;
    sg = mode_c[1] | mode_c[2];
    ov_m = 1'h0;
    a = sg ? longint'($signed(out_m)) : longint'(out_m);
    if (mode_c == MODE_PID) begin
      e = sx({set_c[15], set_c}) - sx({i[15], i});
      a = acc(a, e * sx({k1_c[15], k1_c}), 1'h1);
      a = acc(a, z1_m * sx({k2_c[15], k2_c}), 1'h1);
      a = acc(a, z2_m * sx({k3_c[15], k3_c}), 1'h1);
      z2_m = z1_m;
      z1_m = e;
    end else begin
      if (sg) e = sx({i[15], i}) + sx({set_c[15], set_c});
      else e = longint'(i) + longint'(set_c);
      if (!mode_c[0]) a = 0;
      a = acc(a, e * (sg ? sx({k1_c[15], k1_c}) : longint'(k1_c)), sg);
    end
    out_m = a[34:0];
  endfunction

  task automatic ctx(logic [34:0] o, logic [16:0] h1, logic [16:0] h2);
    wr(ADDR_RESULT_LOW, o[31:0], r);
    wr(ADDR_RESULT_HIGH, {29'h0, o[34:32]}, r);
    wr(ADDR_HISTORY_ONE, {15'h0, h1}, r);
    wr(ADDR_HISTORY_TWO, {15'h0, h2}, r);
    out_m = o;
    z1_m = sx(h1);
    z2_m = sx(h2);
  endtask

  task automatic cfg(logic [2:0] m, logic [15:0] s, k1, k2, k3, logic [1:0] ie);
    {mode_c, set_c, k1_c, k2_c, k3_c, ien} = {m, s, k1, k2, k3, ie};
    wr(ADDR_CONTROL, {29'h0, m}, r);
    wr(ADDR_CONTROL, {24'h0, 5'h1f, m}, r);
    rd(ADDR_CONTROL, d, r);
    chk("control", {24'h0, 5'h10, m}, d);
    wr(ADDR_COEFF_CURRENT, {16'h0, k1}, r);
    wr(ADDR_COEFF_PRIOR, {16'h0, k2}, r);
    wr(ADDR_COEFF_SECOND, {16'h0, k3}, r);
    wr(ADDR_SET_POINT, {16'h0, s}, r);
    wr(ADDR_IRQ_ENABLE, {30'h0, ie}, r);
  endtask

  task automatic run(logic [15:0] i);
    logic [31:0] v, w;
    logic [1:0] q, q2;
    int n;
    model(i);
    wr(ADDR_INPUT_HIGH, {24'h0, i[15:8]}, q);
    fork
      wr(ADDR_INPUT_LOW, {24'h0, i[7:0]}, q);
      begin
        repeat (2) @(posedge aclk);
        rd(ADDR_CONTROL, v, q2);
      end
    join
    chk("busy at start", 1, v[CTRL_BUSY_BIT]);
    n = 0;
    do begin
      rd(ADDR_CONTROL, v, q);
      n++;
    end while (v[CTRL_BUSY_BIT] !== 1'h0 && n < 20);
    chk("busy at end", 0, v[CTRL_BUSY_BIT]);
    rd(ADDR_RESULT_LOW, v, q);
    rd(ADDR_RESULT_HIGH, w, q);
    chk("result", out_m, {w[2:0], v});
    rd(ADDR_HISTORY_ONE, v, q);
    rd(ADDR_HISTORY_TWO, w, q);
    chk("history", {z2_m[16:0], z1_m[16:0]}, {w[16:0], v[16:0]});
    rd(ADDR_IRQ_FLAGS, v, q);
    chk("flags", {ov_m, 1'h1}, v[1:0]);
    chk("irq lines", ien & {ov_m, 1'h1}, {oirq, dirq});
    wr(ADDR_IRQ_FLAGS, 32'h3, q);
    chk("irq cleared", 0, {oirq, dirq});
  endtask

  task automatic note(string t);
    $display("test %s done, %0d mismatches so far", t, err_total);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    forever #2 aclk = ~aclk;
  end

  // About thirty times the expected run length
  initial begin
    #200000;
    err_total++;
    summarize();
  end

  initial begin
    void'($urandom(32'h4d839def));
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    for (int a = 0; a <= ADDR_IRQ_ENABLE; a += 4) begin
      rd(8'(a), d, r);
      chk("reset value", 0, {r, d});
    end
    foreach (bad_addr[j]) begin
      rd(bad_addr[j], d, r);
      chk("unmapped read", {RESP_SLVERR, 32'h0}, {r, d});
      wr(bad_addr[j], 32'hffffffff, r);
      chk("unmapped write", RESP_SLVERR, r);
    end
    note("map");
    wr(ADDR_INPUT_LOW, 32'h5a, r);
    rd(ADDR_CONTROL, d, r);
    chk("idle when disabled", 0, d);
    rd(ADDR_IRQ_FLAGS, d, r);
    chk("no flag when disabled", 0, d);
    note("disabled");
    cfg(MODE_UNSIGNED_PLAIN, 16'hffff, 16'hffff, 16'h0, 16'h0, 2'h3);
    run(16'hffff);
    for (int m = 0; m < 4; m++) begin
      cfg(3'(m), 16'($urandom), 16'($urandom), 16'h0, 16'h0, 2'($urandom));
      for (int n = 0; n < 6; n++) run(n == 0 ? 16'h8000 : 16'($urandom));
    end
    note("add multiply");
    cfg(MODE_SIGNED_ACCUM, 16'h0, 16'h1, 16'h0, 16'h0, 2'h3);
    ctx(35'h3ffffffff, 17'h0, 17'h0);
    run(16'h1);
    cfg(MODE_UNSIGNED_ACCUM, 16'hffff, 16'hffff, 16'h0, 16'h0, 2'h1);
    ctx(35'h7ffffffff, 17'h0, 17'h0);
    run(16'hffff);
    note("overflow");
    cfg(MODE_PID, 16'($urandom), 16'($urandom), 16'($urandom), 16'($urandom), 2'h3);
    for (int n = 0; n < 10; n++) begin
      if (n == 5) ctx({3'($urandom), 32'($urandom)}, 17'($urandom), 17'($urandom));
      run(16'($urandom));
    end
    note("pid");
    summarize();
  end
endmodule // tb_top
`default_nettype wire
